// File: hdl/cti_counter_timer_irq.sv
// counter/timer pair and six-source vectored interrupt logic
// assumes the core owns the register port, samples int_request and
// pulses int_ack once when it enters the interrupt cycle
//
// Function
// - two 8-bit down-counters, each behind its own 6-bit prescaler
// - first prescaler internal clock only; second internal or external
// - prescaler divides its input by any integer 1 to 64
// - counter decrements loaded value, 1 to 256, per prescaler pulse
// - end of count raises request four or request five
// - software start, stop, resume and restart from initial value
// - single-pass halts at zero; modulo-n reloads and continues
// - counters readable without disturbance; prescalers not readable
// - second timer clock is internal clock over four or port pin
// - timer pin as clock, retrigger, non-retrigger trigger or gate
// - first timer end can clock the second timer (cascade)
// - timer pin mode enabled when second prescaler bit 1 is 0
// - six maskable prioritised requests: four pins, two timers
// - mask register enables requests globally and individually
// - six two-byte vectors at bytes 0 to 11, one per request
// - vector byte and the next give 16-bit service address
// - requests one and three trigger on falling pin edges only
// - requests zero and two trigger on rise, fall or both
// - comparator a maps to request two, comparator b to zero
// - priority register orders the encoder among pending requests
// - grant disables further interrupts and starts interrupt cycle
// - polled use: mask inputs and read the request register
// - edge select held in request register bits 7 and 6
`timescale 1ns/1ps
module cti_counter_timer_irq (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire cti_pkg::cti_bus_req_t bus,
	output logic [7:0]                 rdata,
	input  wire logic                  port3_line_zero,
	input  wire logic                  port3_line_one,
	input  wire logic                  port3_line_two,
	input  wire logic                  port3_line_three,
	input  wire logic                  int_ack,
	output logic                       int_request,
	output logic [7:0]                 int_vector
);

	////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] prev;
		logic [7:0] tmr;
		logic [7:0] pre0;
		logic [7:0] second_prescaler_register;
		logic [7:0] t0_init;
		logic [7:0] t1_init;
		logic [7:0] ipr;
		logic [7:0] irq;
		logic [7:0] imr;
		logic [1:0] div4;
		logic [2:0] grant;
		logic [7:0] rdata;
		logic       int_req;
		logic [7:0] vector;
	} cti_top_state_t;

	cti_top_state_t state_q;
	cti_top_state_t state_d;

	cti_pkg::cti_tmr_cfg_t cfg0;
	cti_pkg::cti_tmr_cfg_t cfg1;
	logic [7:0]            t0_count;
	logic [7:0]            t1_count;
	logic                  t0_end;
	logic                  t1_end;
	logic                  t1_running;
	logic                  t0_load;
	logic                  t1_load;
	logic                  t1_tick;
	logic                  div4_tick;

	////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic edge_hit(input logic [1:0] mode,
	                                  input logic rise,
	                                  input logic fall);
		cti_pkg::cti_edge_t m;
		m = cti_pkg::cti_edge_t'(mode);
		unique case (m)
			cti_pkg::EDGE_FALL:     edge_hit = fall;
			cti_pkg::EDGE_RISE:     edge_hit = rise;
			cti_pkg::EDGE_BOTH:     edge_hit = rise | fall;
			cti_pkg::EDGE_BOTH_ALT: edge_hit = rise | fall;
		endcase
	endfunction

	// round-robin start point: the priority code picks which request
	// is searched first, the rest follow in ascending order
	function automatic logic [2:0] pick(input logic [5:0] pend,
	                                    input logic [2:0] start);
		int idx;
		logic found;
		pick  = 3'h0;
		found = 1'b0;
		for (int k = 0; k < cti_pkg::NUM_REQ; k++) begin
			idx = (int'(start) + k) % cti_pkg::NUM_REQ;
			if (!found && pend[idx]) begin
				pick  = 3'(idx);
				found = 1'b1;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// timers

	assign div4_tick = (state_q.div4 == cti_pkg::DIV4_LAST);

	assign cfg0 = '{init:   state_q.t0_init,
	                div:    state_q.pre0[cti_pkg::PRE_DIV_LO +: 6],
	                modulo: state_q.pre0[cti_pkg::PRE_MODULO]};
	assign cfg1 = '{init:   state_q.t1_init,
	                div:    state_q.second_prescaler_register[cti_pkg::PRE_DIV_LO +: 6],
	                modulo: state_q.second_prescaler_register[cti_pkg::PRE_MODULO]};

	always_comb begin
		logic           ext_mode;
		logic           pin_fall;
		logic           ext_clk;
		logic           trig;
		cti_pkg::cti_tin_t external_timer_input;
		ext_mode = !state_q.second_prescaler_register[cti_pkg::PRE_INTCLK];
		pin_fall = state_q.prev[1] & ~state_q.sync2[1];
		external_timer_input      = cti_pkg::cti_tin_t'(state_q.tmr[cti_pkg::TMR_TIN_LO +: 2]);
		ext_clk  = state_q.tmr[cti_pkg::TMR_CASCADE] ? t0_end
		                                             : pin_fall;
		trig     = 1'b0;
		t1_tick  = div4_tick;
		if (ext_mode) begin
			unique case (external_timer_input)
				cti_pkg::TIN_EXT_CLOCK: begin
					t1_tick = ext_clk;
				end
				cti_pkg::TIN_GATE: begin
					t1_tick = div4_tick & state_q.sync2[1];
				end
				cti_pkg::TIN_TRIG_NORETRIG: begin
					trig = pin_fall & ~t1_running;
				end
				cti_pkg::TIN_TRIG_RETRIG: begin
					trig = pin_fall;
				end
			endcase
		end
		t0_load = bus.wr && bus.addr == cti_pkg::ADDR_TMR
		          && bus.wdata[cti_pkg::TMR_LOAD0];
		t1_load = (bus.wr && bus.addr == cti_pkg::ADDR_TMR
		          && bus.wdata[cti_pkg::TMR_LOAD1]) || trig;
	end

	cti_timer u_first_counter_timer (
		.clock     (clock),
		.rst_n     (rst_n),
		.cfg       (cfg0),
		.load      (t0_load),
		.enable    (state_q.tmr[cti_pkg::TMR_EN0]),
		.tick      (div4_tick),
		.count     (t0_count),
		.running   (),
		.end_pulse (t0_end)
	);

	cti_timer u_second_counter_timer (
		.clock     (clock),
		.rst_n     (rst_n),
		.cfg       (cfg1),
		.load      (t1_load),
		.enable    (state_q.tmr[cti_pkg::TMR_EN1]),
		.tick      (t1_tick),
		.count     (t1_count),
		.running   (t1_running),
		.end_pulse (t1_end)
	);

	////////////////////////////////////////////////////////////////////
	// registers, request logic, read port

	always_comb begin
		logic [3:0] rise;
		logic [3:0] fall;
		logic [5:0] set_v;
		logic [5:0] pend;
		logic [2:0] win;
		logic [1:0] edge_mode;
		rise      = ~state_q.prev & state_q.sync2;
		fall      = state_q.prev & ~state_q.sync2;
		edge_mode = state_q.irq[cti_pkg::IRQ_EDGE_LO +: 2];
		set_v     = 6'h00;
		pend      = 6'h00;
		win       = 3'h0;
		state_d   = state_q;

		// pins pass two flops; edges compare the second with a third, one cycle older
		state_d.sync1 = {port3_line_three, port3_line_two,
		                 port3_line_one, port3_line_zero};
		state_d.sync2 = state_q.sync1;
		state_d.prev  = state_q.sync2;
		state_d.div4  = state_q.div4 + 2'h1;

		set_v[0] = edge_hit(edge_mode, rise[2], fall[2]);
		set_v[1] = fall[3];
		set_v[2] = edge_hit(edge_mode, rise[1], fall[1]);
		set_v[3] = fall[0];
		set_v[4] = t0_end;
		set_v[5] = t1_end;

		// software writes
		if (bus.wr) begin
			unique case (bus.addr)
				cti_pkg::ADDR_TMR: begin
					// load bits act once and never stick
					state_d.tmr = bus.wdata;
					state_d.tmr[cti_pkg::TMR_LOAD0] = 1'b0;
					state_d.tmr[cti_pkg::TMR_LOAD1] = 1'b0;
				end
				cti_pkg::ADDR_T0:   state_d.t0_init = bus.wdata;
				cti_pkg::ADDR_T1:   state_d.t1_init = bus.wdata;
				cti_pkg::ADDR_PRE0: begin
					// first timer has no external source
					state_d.pre0 = bus.wdata;
					state_d.pre0[cti_pkg::PRE_INTCLK] = 1'b1;
				end
				cti_pkg::ADDR_SECOND_PRESCALER_REGISTER: state_d.second_prescaler_register = bus.wdata;
				cti_pkg::ADDR_IPR:  state_d.ipr  = bus.wdata;
				cti_pkg::ADDR_IRQ:  state_d.irq  = bus.wdata;
				cti_pkg::ADDR_IMR:  state_d.imr  = bus.wdata;
				default: begin
				end
			endcase
		end

		// grant: clear the request and the global enable
		if (int_ack) begin
			state_d.irq[state_q.grant] = 1'b0;
			state_d.imr[cti_pkg::IMR_GLOBAL] = 1'b0;
		end

		// an event in the clearing cycle is kept: set wins
		state_d.irq[5:0] = state_d.irq[5:0] | set_v;

		pend = state_q.irq[5:0] & state_q.imr[5:0]
		       & {6{state_q.imr[cti_pkg::IMR_GLOBAL]}};
		win  = pick(pend, state_q.ipr[2:0]);
		state_d.grant   = win;
		state_d.int_req = |pend && !int_ack;
		state_d.vector  = {4'h0, win, 1'b0};

		// read port: data only in the cycle after the strobe
		state_d.rdata = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				cti_pkg::ADDR_TMR:  state_d.rdata = state_q.tmr;
				cti_pkg::ADDR_T0:   state_d.rdata = t0_count;
				cti_pkg::ADDR_T1:   state_d.rdata = t1_count;
				cti_pkg::ADDR_IPR:  state_d.rdata = state_q.ipr;
				cti_pkg::ADDR_IRQ:  state_d.rdata = state_q.irq;
				cti_pkg::ADDR_IMR:  state_d.rdata = state_q.imr;
				// prescalers are write-only and read as zero
				default:            state_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= '{sync1:   4'hF,
			             sync2:   4'hF,
			             prev:    4'hF,
			             tmr:     cti_pkg::TMR_RST,
			             pre0:    cti_pkg::PRE_RST,
			             second_prescaler_register:    cti_pkg::PRE_RST,
			             t0_init: cti_pkg::CNT_RST,
			             t1_init: cti_pkg::CNT_RST,
			             ipr:     cti_pkg::IPR_RST,
			             irq:     cti_pkg::IRQ_RST,
			             imr:     cti_pkg::IMR_RST,
			             div4:    2'h0,
			             grant:   3'h0,
			             rdata:   8'h00,
			             int_req: 1'b0,
			             vector:  8'h00};
		end else begin
			state_q <= state_d;
		end
	end

	assign rdata       = state_q.rdata;
	assign int_request = state_q.int_req;
	assign int_vector  = state_q.vector;

endmodule

// File: hdl/cti_pkg.sv
// constants, encodings and carrier types of the counter/timer and
// interrupt unit; assumes an 8-bit register port in the 240..255 range
package cti_pkg;

	////////////////////////////////////////////////////////////////////
	// register addresses
	localparam logic [7:0] ADDR_TMR  = 8'hF1;
	localparam logic [7:0] ADDR_T1   = 8'hF2;
	localparam logic [7:0] ADDR_SECOND_PRESCALER_REGISTER = 8'hF3;
	localparam logic [7:0] ADDR_T0   = 8'hF4;
	localparam logic [7:0] ADDR_PRE0 = 8'hF5;
	localparam logic [7:0] ADDR_IPR  = 8'hF9;
	localparam logic [7:0] ADDR_IRQ  = 8'hFA;
	localparam logic [7:0] ADDR_IMR  = 8'hFB;

	////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] TMR_RST = 8'h00;
	localparam logic [7:0] PRE_RST = 8'h02;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [7:0] IPR_RST = 8'h00;
	localparam logic [7:0] IRQ_RST = 8'h00;
	localparam logic [7:0] IMR_RST = 8'h00;

	////////////////////////////////////////////////////////////////////
	// field positions
	localparam int TMR_LOAD0   = 0;
	localparam int TMR_EN0     = 1;
	localparam int TMR_LOAD1   = 2;
	localparam int TMR_EN1     = 3;
	localparam int TMR_TIN_LO  = 4;
	localparam int TMR_CASCADE = 6;
	localparam int PRE_MODULO  = 0;
	localparam int PRE_INTCLK  = 1;
	localparam int PRE_DIV_LO  = 2;
	localparam int IRQ_EDGE_LO = 6;
	localparam int IMR_GLOBAL  = 7;
	localparam int NUM_REQ     = 6;

	////////////////////////////////////////////////////////////////////
	// timing: internal timer clock is the processor clock divided by 4
	localparam int         INT_CLK_DIV  = 4;
	localparam logic [1:0] DIV4_LAST    = 2'(INT_CLK_DIV - 1);

	////////////////////////////////////////////////////////////////////
	// encodings
	typedef enum logic [1:0] {
		TIN_EXT_CLOCK,
		TIN_GATE,
		TIN_TRIG_NORETRIG,
		TIN_TRIG_RETRIG
	} cti_tin_t;

	typedef enum logic [1:0] {
		EDGE_FALL,
		EDGE_RISE,
		EDGE_BOTH,
		EDGE_BOTH_ALT
	} cti_edge_t;

	////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cti_bus_req_t;

	typedef struct packed {
		logic [7:0] init;
		logic [5:0] div;
		logic       modulo;
	} cti_tmr_cfg_t;

endpackage

// File: hdl/cti_timer.sv
// one 8-bit down-counter with its 6-bit prescaler
// assumes tick is a one-cycle pulse from the same clock domain
`timescale 1ns/1ps
module cti_timer (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire cti_pkg::cti_tmr_cfg_t cfg,
	input  wire logic                  load,
	input  wire logic                  enable,
	input  wire logic                  tick,
	output logic [7:0]                 count,
	output logic                       running,
	output logic                       end_pulse
);

	typedef struct packed {
		logic [5:0] pre;
		logic [7:0] cnt;
		logic       halted;
		logic       eoc;
	} cti_tmr_state_t;

	cti_tmr_state_t state_q;
	cti_tmr_state_t state_d;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		state_d     = state_q;
		state_d.eoc = 1'b0;
		if (load) begin
			state_d.cnt    = cfg.init;
			state_d.pre    = cfg.div - 6'h01;
			state_d.halted = 1'b0;
		end else if (enable && !state_q.halted && tick) begin
			if (state_q.pre == 6'h00) begin
				// div code 0 wraps to 63: divide by 64
				state_d.pre = cfg.div - 6'h01;
				if (state_q.cnt == 8'h01) begin
					state_d.eoc = 1'b1;
					if (cfg.modulo) begin
						state_d.cnt = cfg.init;
					end else begin
						state_d.cnt    = 8'h00;
						state_d.halted = 1'b1;
					end
				end else begin
					// init 0 wraps to FF so it counts 256
					state_d.cnt = state_q.cnt - 8'h01;
				end
			end else begin
				state_d.pre = state_q.pre - 6'h01;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= '{pre: 6'h00, cnt: 8'h00, halted: 1'b1, eoc: 1'b0};
		end else begin
			state_q <= state_d;
		end
	end

	assign count     = state_q.cnt;
	assign running   = enable && !state_q.halted;
	assign end_pulse = state_q.eoc;

endmodule

// File: testbench/cti_monitor.sv
// port checker of the counter/timer and interrupt unit
// assumes one clock domain; bound to the top module at the foot
`timescale 1ns/1ps
module cti_monitor (
	input wire logic                  clock,
	input wire logic                  rst_n,
	input wire cti_pkg::cti_bus_req_t bus,
	input wire logic [7:0]            rdata,
	input wire logic                  port3_line_zero,
	input wire logic                  port3_line_one,
	input wire logic                  port3_line_two,
	input wire logic                  port3_line_three,
	input wire logic                  int_ack,
	input wire logic                  int_request,
	input wire logic [7:0]            int_vector
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// shadow of the mask: the port shows it only when read
	logic [7:0] imr_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			imr_q <= 8'h00;
		else begin
			if (bus.wr && bus.addr == cti_pkg::ADDR_IMR)
				imr_q <= bus.wdata;
			// a grant clears the global enable even over a write
			if (int_ack)
				imr_q[7] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	sequence s_mask_off;
		bus.wr && bus.addr == cti_pkg::ADDR_IMR &&
		(!bus.wdata[7] || bus.wdata[5:0] == 6'h00);
	endsequence
	sequence s_off2;
		!imr_q[7] ##1 !imr_q[7];
	endsequence

	property p_rd_idle;
		!bus.rd |=> rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data seen without a read");
	property p_pre_hidden;
		bus.rd && (bus.addr == cti_pkg::ADDR_PRE0 ||
		bus.addr == cti_pkg::ADDR_SECOND_PRESCALER_REGISTER) |=> rdata == 8'h00;
	endproperty
	a_pre_hidden: assert property (p_pre_hidden)
		else $error("prescaler contents readable");
	property p_ack_drop;
		int_ack && int_request && !bus.wr |=> !int_request;
	endproperty
	a_ack_drop: assert property (p_ack_drop)
		else $error("request stays after grant");
	property p_vec_slot;
		int_request |-> !int_vector[0] && int_vector <= 8'h0A;
	endproperty
	a_vec_slot: assert property (p_vec_slot)
		else $error("vector outside the six slots");
	property p_glob_off;
		s_mask_off |=> ##1 !int_request;
	endproperty
	a_glob_off: assert property (p_glob_off)
		else $error("request passes a closed mask");
	property p_req_off;
		s_off2 |-> !int_request;
	endproperty
	a_req_off: assert property (p_req_off)
		else $error("request while globally disabled");
	property p_fall_one;
		$fell(port3_line_three) && imr_q[7] && imr_q[1]
		|-> ##[1:8] int_request;
	endproperty
	a_fall_one: assert property (p_fall_one)
		else $error("falling edge on line three lost");
	property p_fall_three;
		$fell(port3_line_zero) && imr_q[7] && imr_q[3]
		|-> ##[1:8] int_request;
	endproperty
	a_fall_three: assert property (p_fall_three)
		else $error("falling edge on line zero lost");
endmodule

bind cti_counter_timer_irq cti_monitor u_mon (
	.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata),
	.port3_line_zero(port3_line_zero), .port3_line_one(port3_line_one),
	.port3_line_two(port3_line_two), .port3_line_three(port3_line_three),
	.int_ack(int_ack), .int_request(int_request), .int_vector(int_vector)
);

// File: testbench/cti_core_model.sv
// processor core model: grants a pending request after a set lag
// assumes the unit holds int_request and int_vector until acked
`timescale 1ns/1ps
module cti_core_model (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       ack_on,
	input  wire logic [3:0] lag,
	input  wire logic       int_request,
	input  wire logic [7:0] int_vector,
	output logic            int_ack,
	output logic [7:0]      fetch_hi,
	output logic [7:0]      fetch_lo,
	output int              grants
);
	initial begin
		int_ack = 1'b0;
		fetch_hi = 8'h00;
		fetch_lo = 8'h00;
		grants = 0;
		forever begin
			@(posedge clock);
			if (rst_n && ack_on && int_request) begin
				repeat (lag) @(posedge clock);
				int_ack <= 1'b1;
				fetch_hi <= int_vector;
				fetch_lo <= int_vector + 8'h01;
				grants <= grants + 1;
				@(posedge clock);
				int_ack <= 1'b0;
				// one quiet edge so a grant is never acked twice
				@(posedge clock);
			end
		end
	end
endmodule

// File: testbench/cti_counter_timer_irq_test.sv
// self-checking bench of the counter/timer and interrupt unit
// assumes the core model acks grants and the pins idle high
`timescale 1ns/1ps
module cti_counter_timer_irq_test;
	logic                  clock;
	logic                  rst_n;
	cti_pkg::cti_bus_req_t bus;
	logic [7:0]            rdata;
	logic [3:0]            pin;
	logic                  ack_on;
	logic [3:0]            lag;
	logic                  int_ack;
	logic                  int_request;
	logic [7:0]            int_vector;
	logic [7:0]            fhi;
	logic [7:0]            flo;
	logic [7:0]            v;
	logic [7:0]            w;
	int                    grants;
	int                    bad_count;
	int                    cmp_count;
	int                    cyc;

	cti_counter_timer_irq dut (.clock(clock), .rst_n(rst_n), .bus(bus),
		.rdata(rdata), .port3_line_zero(pin[0]), .port3_line_one(pin[1]),
		.port3_line_two(pin[2]), .port3_line_three(pin[3]),
		.int_ack(int_ack), .int_request(int_request),
		.int_vector(int_vector));
	cti_core_model core (.clock(clock), .rst_n(rst_n), .ack_on(ack_on),
		.lag(lag), .int_request(int_request), .int_vector(int_vector),
		.int_ack(int_ack), .fetch_hi(fhi), .fetch_lo(flo), .grants(grants));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// the whole run needs some 2200 cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(logic [7:0] a);
		@(posedge clock);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic rchk(string n, logic [7:0] a, logic [7:0] e);
		rd(a);
		chk(n, e, v);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rchk("mode", cti_pkg::ADDR_TMR, cti_pkg::TMR_RST);
		rchk("count", cti_pkg::ADDR_T0, cti_pkg::CNT_RST);
		rchk("mask", cti_pkg::ADDR_IMR, cti_pkg::IMR_RST);
		wr(cti_pkg::ADDR_PRE0, 8'h5A);
		rchk("pre", cti_pkg::ADDR_PRE0, 8'h00);
		wr(8'h10, 8'h5A);
		rchk("gap", 8'h10, 8'h00);
		wr(cti_pkg::ADDR_IRQ, 8'hC0);
		rchk("edge", cti_pkg::ADDR_IRQ, 8'hC0);
	endtask
	// e: expected cycles, initial value x divide x 4
	task automatic t_time(logic [7:0] ini, logic [7:0] pre, int e);
		int n;
		wr(cti_pkg::ADDR_IRQ, 8'h00);
		wr(cti_pkg::ADDR_IMR, 8'h90);
		wr(cti_pkg::ADDR_T0, ini);
		wr(cti_pkg::ADDR_PRE0, pre);
		wr(cti_pkg::ADDR_TMR, 8'h03);
		n = 0;
		while (int_request !== 1'b1 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		chk("period", 8'h01, 8'(n >= e - 4 && n <= e + 12));
		rchk("halt", cti_pkg::ADDR_T0, 8'h00);
		wr(cti_pkg::ADDR_IMR, 8'h00);
	endtask
	task automatic t_modulo();
		wr(cti_pkg::ADDR_IRQ, 8'h00);
		wr(cti_pkg::ADDR_T1, 8'h03);
		wr(cti_pkg::ADDR_SECOND_PRESCALER_REGISTER, 8'h07);
		wr(cti_pkg::ADDR_TMR, 8'h0C);
		rchk("mode", cti_pkg::ADDR_TMR, 8'h08);
		repeat (20) @(posedge clock);
		rchk("end", cti_pkg::ADDR_IRQ, 8'h20);
		wr(cti_pkg::ADDR_IRQ, 8'h00);
		repeat (20) @(posedge clock);
		rchk("again", cti_pkg::ADDR_IRQ, 8'h20);
		wr(cti_pkg::ADDR_TMR, 8'h00);
		// a modulo count never shows zero: it reloads from one
		rd(cti_pkg::ADDR_T1);
		chk("peek", 8'h01, 8'(v >= 8'h01 && v <= 8'h03));
		w = v;
		repeat (20) @(posedge clock);
		rchk("stop", cti_pkg::ADDR_T1, w);
		wr(cti_pkg::ADDR_TMR, 8'h08);
		repeat (6) @(posedge clock);
		rd(cti_pkg::ADDR_T1);
		chk("peek", 8'h01, 8'(v >= 8'h01 && v <= 8'h03));
		chk("resume", 8'h01, 8'(v != w));
		wr(cti_pkg::ADDR_TMR, 8'h00);
	endtask
	// pin i falls, core grants after l edges, then pin rises
	task automatic t_pin(int i, logic [7:0] vec, logic [3:0] l);
		int g;
		g = grants;
		wr(cti_pkg::ADDR_IRQ, 8'h00);
		wr(cti_pkg::ADDR_IMR, 8'h80 | (8'h01 << vec[3:1]));
		ack_on <= 1'b1;
		lag <= l;
		pin[i] <= 1'b0;
		repeat (30) @(posedge clock);
		chk("grants", 8'(g + 1), 8'(grants));
		chk("vector", vec, fhi);
		chk("low", vec + 8'h01, flo);
		rchk("served", cti_pkg::ADDR_IRQ, 8'h00);
		rchk("closed", cti_pkg::ADDR_IMR, 8'h01 << vec[3:1]);
		pin[i] <= 1'b1;
		repeat (12) @(posedge clock);
		rchk("rise", cti_pkg::ADDR_IRQ, 8'h00);
		ack_on <= 1'b0;
	endtask
	// pin one feeds request two, pin two feeds request zero
	task automatic t_edge();
		logic [7:0] m;
		logic [7:0] e;
		for (int s = 0; s < 4; s++) begin
			for (int k = 1; k < 3; k++) begin
				m = 8'(s << 6);
				e = (k == 1) ? 8'h04 : 8'h01;
				wr(cti_pkg::ADDR_IRQ, m);
				pin[k] <= 1'b0;
				repeat (8) @(posedge clock);
				rchk("fall", cti_pkg::ADDR_IRQ, m | (s != 1 ? e : 8'h00));
				wr(cti_pkg::ADDR_IRQ, m);
				pin[k] <= 1'b1;
				repeat (8) @(posedge clock);
				rchk("rise", cti_pkg::ADDR_IRQ, m | (s != 0 ? e : 8'h00));
			end
		end
	endtask
	// pin one as clock, first timer cascaded in, pin one as retrigger
	task automatic t_ext();
		wr(cti_pkg::ADDR_IRQ, 8'h00);
		wr(cti_pkg::ADDR_T1, 8'h02);
		wr(cti_pkg::ADDR_SECOND_PRESCALER_REGISTER, 8'h05);
		wr(cti_pkg::ADDR_TMR, 8'h0C);
		for (int f = 1; f < 3; f++) begin
			pin[1] <= 1'b0;
			repeat (8) @(posedge clock);
			rchk("pin clock", cti_pkg::ADDR_T1, 8'(f));
			@(posedge clock);
			pin[1] <= 1'b1;
			repeat (8) @(posedge clock);
		end
		rchk("pin end", cti_pkg::ADDR_IRQ, 8'h24);
		wr(cti_pkg::ADDR_IRQ, 8'h00);
		wr(cti_pkg::ADDR_T0, 8'h01);
		wr(cti_pkg::ADDR_PRE0, 8'h07);
		wr(cti_pkg::ADDR_T1, 8'h03);
		wr(cti_pkg::ADDR_TMR, 8'h4F);
		repeat (20) @(posedge clock);
		rchk("cascade", cti_pkg::ADDR_IRQ, 8'h30);
		wr(cti_pkg::ADDR_SECOND_PRESCALER_REGISTER, 8'h04);
		wr(cti_pkg::ADDR_TMR, 8'h38);
		repeat (20) @(posedge clock);
		wr(cti_pkg::ADDR_IRQ, 8'h00);
		rchk("halted", cti_pkg::ADDR_T1, 8'h00);
		@(posedge clock);
		pin[1] <= 1'b0;
		repeat (20) @(posedge clock);
		rchk("trigger", cti_pkg::ADDR_IRQ, 8'h24);
		@(posedge clock);
		pin[1] <= 1'b1;
		wr(cti_pkg::ADDR_TMR, 8'h00);
	endtask
	task automatic t_prio();
		wr(cti_pkg::ADDR_IMR, 8'h8A);
		for (int s = 0; s < 6; s += 2) begin
			wr(cti_pkg::ADDR_IPR, 8'(s));
			wr(cti_pkg::ADDR_IRQ, 8'h0A);
			repeat (3) @(posedge clock);
			#1 chk("prio", (s == 2) ? 8'h06 : 8'h02, int_vector);
		end
		wr(cti_pkg::ADDR_IMR, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		bus = '0;
		pin = 4'hF;
		ack_on = 1'b0;
		lag = 4'h0;
		rst_n = 1'b0;
		bad_count = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_time(8'h01, 8'h06, 4);
		t_time(8'h02, 8'h02, 512);
		t_time(8'h00, 8'h06, 1024);
		t_modulo();
		t_pin(3, 8'h02, 4'h0);
		t_pin(0, 8'h06, 4'h5);
		t_edge();
		t_ext();
		t_prio();
		finish_test();
	end
endmodule
